//--- logic/fpsd_pkg.sv
// Package of constants and types for the front-panel status and digital I/O configuration block
// How it works
// - One LED per DSP, up to five, lit steadily during normal operation.
// - A DSP whose load passed 99 percent in its last completed cycle flashes its LED about 3 Hz.
// - Display: top line run/idle and headings, bottom line per-DSP values plus aggregate.
// - Short button press advances option; one-second hold before release starts auto cycling.
// - Indicators: cycle usage, overage count, bus capacity percent, transfer capacity percent.
// - Display can also show booting message and blank-microcode message.
// - Optical port carries up to 16 channels numbered 1 to 16 from fixed base.
// - 6.25 Mbit/s link limits 16 channels of 16 bits to 24.414 kHz frames.
// - Base station oversamples optical samples up to 4X for 50 or 100 kHz processing.
// - Amp light: solid connected, 2 s flash absent, 1 s charging, rapid low battery.
// - Near-clipping on any amplifier channel flashes amp light very rapidly.
// - By default bit lights follow the eight bit-addressable lines, lit when high.
// - Amp-status mode: lights 0 to 3 show power pattern, 4 to 7 clip warning.
// - Output converter delay 43 samples, input converter delay 70 samples.
// - Local analog inputs appear at channels 128 and 129.
// - Eight bit lines have own direction; each byte port has one direction.
// - After reset all digital lines are inputs until configured as outputs.
// - Lines 0 to 3 also feed the sub-microsecond event time stamper.
// - The direction configuration word also selects what the bit lights show.
// - Config bits 0-7 bit-line directions, bit 8 byte A, bit 9 byte B; one is output.
// - Light code bits 12-14: 000 bit lines, 010 amp status, 100 byte A, 101 byte B.
package fpsd_pkg;
   localparam int          CLOCK_HZ          = 100_000_000;
   localparam int          NUM_DSP           = 5;
   localparam logic [11:0] ADDR_CONFIG       = 12'h000;
   localparam logic [11:0] ADDR_DSP_STAT     = 12'h004;
   localparam logic [11:0] ADDR_DISP         = 12'h008;
   localparam logic [11:0] ADDR_DIO          = 12'h00C;
   localparam logic [11:0] ADDR_INFO         = 12'h010;
   localparam logic [11:0] ADDR_STAMP        = 12'h014;
   localparam int          CFG_BYTE_A        = 8;
   localparam int          CFG_BYTE_B        = 9;
   localparam int          CFG_CODE_LO       = 12;
   localparam logic [15:0] CFG_MASK          = 16'h73FF;
   localparam logic [15:0] CFG_RESET         = 16'h0000;
   localparam logic [2:0]  LIGHT_BITS        = 3'h0;
   localparam logic [2:0]  LIGHT_AMP         = 3'h2;
   localparam logic [2:0]  LIGHT_BYTE_A      = 3'h4;
   localparam logic [2:0]  LIGHT_BYTE_B      = 3'h5;
   localparam logic [6:0]  LOAD_LIMIT_PCT    = 7'h63;
   localparam logic [4:0]  OPT_FIRST_CH      = 5'h01;
   localparam logic [4:0]  OPT_NUM_CH        = 5'h10;
   localparam logic [7:0]  ADC_CH0           = 8'h80;
   localparam logic [7:0]  ADC_CH1           = 8'h81;
   localparam logic [7:0]  DAC_DELAY_SAMP    = 8'h2B;
   localparam logic [7:0]  ADC_DELAY_SAMP    = 8'h46;
   localparam int          LINK_BPS          = 6_250_000;
   localparam int          MAX_FRAME_HZ      = LINK_BPS / (16 * 16);
   localparam logic [2:0]  MAX_OVERSAMPLE    = 3'h4;
   // Flash half periods, button hold time and auto-cycle step in milliseconds
   localparam int          DSP_FLASH_MS      = 167;
   localparam int          VSLOW_MS          = 1000;
   localparam int          SLOW_MS           = 500;
   localparam int          RAPID_MS          = 125;
   localparam int          VRAPID_MS         = 50;
   localparam int          HOLD_MS           = 1000;
   localparam int          AUTO_MS           = 2000;
   localparam int          MS_CYCLES         = CLOCK_HZ / 1000;
   localparam logic [10:0] ZERO_MS           = 11'h000;
   localparam logic [16:0] ZERO_TICK         = 17'h00000;

   typedef enum logic [3:0] {
      FPSD_SHOW_CYC  = 4'b0001,
      FPSD_SHOW_OVR  = 4'b0010,
      FPSD_SHOW_BUS  = 4'b0100,
      FPSD_SHOW_IO   = 4'b1000
   } fpsd_show_e;

   typedef struct packed {
      logic       connected;
      logic       charging;
      logic       low_batt;
      logic       clip;
   } fpsd_amp_s;

   typedef struct packed {
      logic [1:0]  message;
      logic        running;
      logic [3:0]  indicator;
      logic        auto_cycle;
   } fpsd_disp_s;
endpackage

//--- logic/fpsd_top.sv
// Front-panel status lights, status display control and digital I/O configuration with APB slave
`timescale 1ns/10ps
module fpsd_top
#(
   parameter int HOLD_CYCLES = fpsd_pkg::HOLD_MS * fpsd_pkg::MS_CYCLES,
   parameter int MS_TICK     = fpsd_pkg::MS_CYCLES
)
(
   input  wire logic                         clock,
   input  wire logic                         reset,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [11:0]                  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic                              pready,
   output logic      [31:0]                  prdata,
   output logic                              pslverr,
   input  wire logic [fpsd_pkg::NUM_DSP-1:0] dsp_present,
   input  wire logic [fpsd_pkg::NUM_DSP-1:0] dsp_cycle_end,
   input  wire logic [6:0]                   dsp_load_pct [fpsd_pkg::NUM_DSP],
   input  wire logic                         system_running,
   input  wire logic                         dsp_booting,
   input  wire logic                         firmware_blank,
   input  wire logic                         mode_button,
   input  wire fpsd_pkg::fpsd_amp_s          amp_status,
   input  wire logic [7:0]                   bit_in,
   input  wire logic [15:0]                  word_in,
   output logic      [fpsd_pkg::NUM_DSP-1:0] dsp_led,
   output logic                              amp_light,
   output logic      [7:0]                   bit_lights,
   output fpsd_pkg::fpsd_disp_s              status_display,
   output logic      [7:0]                   bit_out,
   output logic      [7:0]                   bit_oe,
   output logic      [15:0]                  word_out,
   output logic      [15:0]                  word_oe,
   output logic      [3:0]                   stamp_event
);
   // Millisecond tick and flash phase generators
   logic [16:0] tick_q;
   logic [10:0] ms_q;
   logic        ms_tick;
   logic        dsp_ph_q, vslow_ph_q, slow_ph_q, rapid_ph_q, vrapid_ph_q;
   logic [10:0] c_dsp_q, c_vslow_q, c_slow_q, c_rapid_q, c_vrapid_q;
   assign ms_tick = (tick_q == 17'(MS_TICK - 1));

   always_ff @(posedge clock or posedge reset)
      if (reset)
         tick_q <= fpsd_pkg::ZERO_TICK;
      else
         tick_q <= ms_tick ? fpsd_pkg::ZERO_TICK : tick_q + 17'h00001;

   // One divider per pattern, each with its own fixed half period
   always_ff @(posedge clock or posedge reset)
      if (reset)
      begin
         c_dsp_q     <= fpsd_pkg::ZERO_MS;
         dsp_ph_q    <= 1'b0;
         c_vslow_q   <= fpsd_pkg::ZERO_MS;
         vslow_ph_q  <= 1'b0;
         c_slow_q    <= fpsd_pkg::ZERO_MS;
         slow_ph_q   <= 1'b0;
         c_rapid_q   <= fpsd_pkg::ZERO_MS;
         rapid_ph_q  <= 1'b0;
         c_vrapid_q  <= fpsd_pkg::ZERO_MS;
         vrapid_ph_q <= 1'b0;
      end
      else if (ms_tick)
      begin
         c_dsp_q    <= (c_dsp_q == 11'(fpsd_pkg::DSP_FLASH_MS - 1)) ? fpsd_pkg::ZERO_MS : c_dsp_q + 11'h001;
         dsp_ph_q   <= dsp_ph_q ^ (c_dsp_q == 11'(fpsd_pkg::DSP_FLASH_MS - 1));
         c_vslow_q  <= (c_vslow_q == 11'(fpsd_pkg::VSLOW_MS - 1)) ? fpsd_pkg::ZERO_MS : c_vslow_q + 11'h001;
         vslow_ph_q <= vslow_ph_q ^ (c_vslow_q == 11'(fpsd_pkg::VSLOW_MS - 1));
         c_slow_q   <= (c_slow_q == 11'(fpsd_pkg::SLOW_MS - 1)) ? fpsd_pkg::ZERO_MS : c_slow_q + 11'h001;
         slow_ph_q  <= slow_ph_q ^ (c_slow_q == 11'(fpsd_pkg::SLOW_MS - 1));
         c_rapid_q  <= (c_rapid_q == 11'(fpsd_pkg::RAPID_MS - 1)) ? fpsd_pkg::ZERO_MS : c_rapid_q + 11'h001;
         rapid_ph_q <= rapid_ph_q ^ (c_rapid_q == 11'(fpsd_pkg::RAPID_MS - 1));
         c_vrapid_q <= (c_vrapid_q == 11'(fpsd_pkg::VRAPID_MS - 1)) ? fpsd_pkg::ZERO_MS : c_vrapid_q + 11'h001;
         vrapid_ph_q <= vrapid_ph_q ^ (c_vrapid_q == 11'(fpsd_pkg::VRAPID_MS - 1));
      end

   // Configuration register and APB decode
   logic [15:0] config_q;
   logic [15:0] word_data_q;
   logic [7:0]  bit_data_q;
   logic [fpsd_pkg::NUM_DSP-1:0] over_q;
   logic [4:0]  ovr_count_q [fpsd_pkg::NUM_DSP];
   logic        access, wr_en, rd_en, addr_ok;
   logic [31:0] rd_mux;
   logic [2:0]  light_code;
   assign access     = psel & penable;
   assign wr_en      = access & pwrite;
   assign rd_en      = access & ~pwrite;
   assign light_code = config_q[fpsd_pkg::CFG_CODE_LO +: 3];
   assign addr_ok    = (paddr == fpsd_pkg::ADDR_CONFIG) | (paddr == fpsd_pkg::ADDR_DSP_STAT)
                     | (paddr == fpsd_pkg::ADDR_DISP) | (paddr == fpsd_pkg::ADDR_DIO)
                     | (paddr == fpsd_pkg::ADDR_INFO) | (paddr == fpsd_pkg::ADDR_STAMP);
   // Both byte ports share one word register; a single access reaches both
   assign rd_mux = (paddr == fpsd_pkg::ADDR_CONFIG)   ? {16'h0000, config_q} :
                   (paddr == fpsd_pkg::ADDR_DSP_STAT) ? {2'h0, ovr_count_q[4], ovr_count_q[3], ovr_count_q[2],
                                                         ovr_count_q[1], ovr_count_q[0], over_q} :
                   (paddr == fpsd_pkg::ADDR_DISP)     ? {24'h000000, status_display} :
                   (paddr == fpsd_pkg::ADDR_DIO)      ? {word_in, 8'h00, bit_in} :
                   (paddr == fpsd_pkg::ADDR_INFO)     ? {fpsd_pkg::ADC_DELAY_SAMP, fpsd_pkg::DAC_DELAY_SAMP,
                                                         fpsd_pkg::ADC_CH1, fpsd_pkg::ADC_CH0} :
                   (paddr == fpsd_pkg::ADDR_STAMP)    ? {16'(fpsd_pkg::MAX_FRAME_HZ), fpsd_pkg::MAX_OVERSAMPLE[2:0], 3'h0,
                                                         fpsd_pkg::OPT_NUM_CH, fpsd_pkg::OPT_FIRST_CH} :
                   32'h00000000;

   always_ff @(posedge clock or posedge reset)
      if (reset)
      begin
         config_q    <= fpsd_pkg::CFG_RESET;
         word_data_q <= 16'h0000;
         bit_data_q  <= 8'h00;
         pready      <= 1'b0;
         prdata      <= 32'h00000000;
         pslverr     <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
         if (wr_en & pready & (paddr == fpsd_pkg::ADDR_CONFIG))
            config_q <= pwdata[15:0] & fpsd_pkg::CFG_MASK;
         if (wr_en & pready & (paddr == fpsd_pkg::ADDR_DIO))
         begin
            bit_data_q  <= pwdata[7:0];
            word_data_q <= pwdata[31:16];
         end
      end

   // DSP load overage latch per cycle
   always_ff @(posedge clock or posedge reset)
      if (reset)
      begin
         over_q <= '0;
         for (int i = 0; i < fpsd_pkg::NUM_DSP; i++)
            ovr_count_q[i] <= 5'h00;
      end
      else
         for (int i = 0; i < fpsd_pkg::NUM_DSP; i++)
            if (dsp_cycle_end[i])
            begin
               over_q[i] <= dsp_load_pct[i] > fpsd_pkg::LOAD_LIMIT_PCT;
               if (dsp_load_pct[i] > fpsd_pkg::LOAD_LIMIT_PCT)
                  ovr_count_q[i] <= ovr_count_q[i] + 5'h01;
            end

   // Mode button: short press advances, one-second hold starts auto cycling
   logic        btn_q;
   logic [31:0] hold_q;
   logic [11:0] auto_q;
   logic        auto_q_on;
   fpsd_pkg::fpsd_show_e show_q, show_next;
   logic        release_ev, advance;
   assign release_ev = btn_q & ~mode_button;
   assign advance    = (release_ev & (hold_q < 32'(HOLD_CYCLES)))
                     | (auto_q_on & ms_tick & (auto_q == 12'(fpsd_pkg::AUTO_MS - 1)));
   always_comb
   begin
      unique case (show_q)
         fpsd_pkg::FPSD_SHOW_CYC: show_next = fpsd_pkg::FPSD_SHOW_OVR;
         fpsd_pkg::FPSD_SHOW_OVR: show_next = fpsd_pkg::FPSD_SHOW_BUS;
         fpsd_pkg::FPSD_SHOW_BUS: show_next = fpsd_pkg::FPSD_SHOW_IO;
         fpsd_pkg::FPSD_SHOW_IO:  show_next = fpsd_pkg::FPSD_SHOW_CYC;
         default:                 show_next = fpsd_pkg::FPSD_SHOW_CYC;
      endcase
   end

   always_ff @(posedge clock or posedge reset)
      if (reset)
      begin
         btn_q     <= 1'b0;
         hold_q    <= 32'h00000000;
         auto_q    <= 12'h000;
         auto_q_on <= 1'b0;
         show_q    <= fpsd_pkg::FPSD_SHOW_CYC;
      end
      else
      begin
         btn_q  <= mode_button;
         hold_q <= mode_button ? ((hold_q == 32'hFFFFFFFF) ? hold_q : hold_q + 32'h00000001) : 32'h00000000;
         if (release_ev)
            auto_q_on <= hold_q >= 32'(HOLD_CYCLES);
         if (ms_tick)
            auto_q <= (auto_q == 12'(fpsd_pkg::AUTO_MS - 1)) ? 12'h000 : auto_q + 12'h001;
         if (advance)
            show_q <= show_next;
      end

   // Outputs
   logic [3:0] power_pat;
   logic       amp_pat, clip_pat;
   assign clip_pat = amp_status.clip & vrapid_ph_q;
   assign amp_pat  = amp_status.clip      ? vrapid_ph_q :
                     amp_status.low_batt  ? rapid_ph_q :
                     amp_status.charging  ? slow_ph_q :
                     amp_status.connected ? 1'b1 : vslow_ph_q;
   assign power_pat = {4{amp_status.low_batt ? rapid_ph_q : amp_status.charging ? slow_ph_q :
                         amp_status.connected ? 1'b1 : vslow_ph_q}};

   always_ff @(posedge clock or posedge reset)
      if (reset)
      begin
         dsp_led        <= '0;
         amp_light      <= 1'b0;
         bit_lights     <= 8'h00;
         status_display <= '0;
         bit_out        <= 8'h00;
         bit_oe         <= 8'h00;
         word_out       <= 16'h0000;
         word_oe        <= 16'h0000;
         stamp_event    <= 4'h0;
      end
      else
      begin
         for (int i = 0; i < fpsd_pkg::NUM_DSP; i++)
            dsp_led[i] <= dsp_present[i] & (~over_q[i] | dsp_ph_q);
         amp_light <= amp_pat;
         unique case (light_code)
            fpsd_pkg::LIGHT_AMP:    bit_lights <= {{4{clip_pat}}, power_pat};
            fpsd_pkg::LIGHT_BYTE_A: bit_lights <= word_in[7:0];
            fpsd_pkg::LIGHT_BYTE_B: bit_lights <= word_in[15:8];
            default:                bit_lights <= bit_in;
         endcase
         status_display <= '{message: {firmware_blank, dsp_booting}, running: system_running,
                             indicator: show_q, auto_cycle: auto_q_on};
         bit_oe   <= config_q[7:0];
         word_oe  <= {{8{config_q[fpsd_pkg::CFG_BYTE_B]}}, {8{config_q[fpsd_pkg::CFG_BYTE_A]}}};
         bit_out  <= bit_data_q;
         word_out <= word_data_q;
         stamp_event <= bit_in[3:0];
      end

   // Assertions
   reset_inputs_a: assert property (@(posedge clock) $fell(reset) |-> (bit_oe == 8'h00 && word_oe == 16'h0000))
      else $error("digital lines not inputs after reset");
   byte_dir_a: assert property (@(posedge clock) disable iff (reset)
      word_oe[15:8] == {8{$past(config_q[fpsd_pkg::CFG_BYTE_B])}})
      else $error("byte B direction mismatch");
   bit_dir_a: assert property (@(posedge clock) disable iff (reset) bit_oe == $past(config_q[7:0]))
      else $error("bit line direction mismatch");
   light_default_a: assert property (@(posedge clock) disable iff (reset)
      $past(light_code) == fpsd_pkg::LIGHT_BITS |-> bit_lights == $past(bit_in))
      else $error("bit lights do not follow lines");
   light_byte_a: assert property (@(posedge clock) disable iff (reset)
      $past(light_code) == fpsd_pkg::LIGHT_BYTE_B |-> bit_lights == $past(word_in[15:8]))
      else $error("bit lights do not follow byte B");
   amp_solid_a: assert property (@(posedge clock) disable iff (reset)
      $past(amp_status) == 4'b1000 |-> amp_light)
      else $error("amp light not solid when connected");
   dsp_steady_a: assert property (@(posedge clock) disable iff (reset)
      $past(dsp_present[0] & ~over_q[0]) |-> dsp_led[0])
      else $error("dsp led not steady");
   stamp_follow_a: assert property (@(posedge clock) disable iff (reset) stamp_event == $past(bit_in[3:0]))
      else $error("time stamp lines mismatch");
endmodule

//--- test/fpsd_panel_user.sv
// Model of the front-panel user and the optically linked amplifier
`timescale 1ns/10ps
module fpsd_panel_user
(
   input  wire logic                clock,
   input  wire logic                reset,
   input  wire logic                press_go,
   input  wire logic [15:0]         press_len,
   input  wire fpsd_pkg::fpsd_amp_s amp_cmd,
   output logic                     mode_button,
   output fpsd_pkg::fpsd_amp_s      amp_status
);
   logic [15:0] left_q;
   // Button held for the commanded count, then released
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         left_q      <= 16'h0000;
         mode_button <= 1'b0;
         amp_status  <= '0;
      end
      else
      begin
         left_q      <= press_go ? press_len : ((left_q != 16'h0000) ? left_q - 16'h0001 : left_q);
         mode_button <= press_go | (left_q > 16'h0001);
         amp_status  <= amp_cmd;
      end
   end
endmodule

//--- test/fpsd_top_bench.sv
// Self-checking bench of the front-panel status and digital I/O block
`timescale 1ns/10ps
module fpsd_top_bench;
   localparam int MS = 10;
   logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic pready, pslverr, err, running = 1'b0, booting = 1'b0, blank = 1'b0, button, amp_light, go = 1'b0;
   logic [4:0] present = 5'h00, cyc_end = 5'h00, dsp_led;
   logic [6:0] load [fpsd_pkg::NUM_DSP] = '{default: 7'h00};
   logic [7:0] bit_in = 8'h00, bit_lights, bit_out, bit_oe;
   logic [15:0] word_in = 16'h0000, word_out, word_oe, plen = 16'h0000;
   logic [3:0] stamp;
   fpsd_pkg::fpsd_amp_s amp_cmd = '0, amp_status;
   fpsd_pkg::fpsd_disp_s disp;
   int n_errors = 0, comparisons = 0, sel = 0, h;
   logic [31:0] cfg;
   logic [3:0] ind;
   wire watch = (sel == 0) ? amp_light : (sel == 1) ? dsp_led[2] : (sel == 2) ? bit_lights[0] : bit_lights[4];
   always #5 clock = ~clock;
   fpsd_top #(.HOLD_CYCLES(50), .MS_TICK(MS)) fpsd_top_inst (.clock(clock), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .dsp_present(present), .dsp_cycle_end(cyc_end), .dsp_load_pct(load),
      .system_running(running), .dsp_booting(booting), .firmware_blank(blank), .mode_button(button),
      .amp_status(amp_status), .bit_in(bit_in), .word_in(word_in), .dsp_led(dsp_led), .amp_light(amp_light),
      .bit_lights(bit_lights), .status_display(disp), .bit_out(bit_out), .bit_oe(bit_oe), .word_out(word_out),
      .word_oe(word_oe), .stamp_event(stamp));
   fpsd_panel_user fpsd_panel_user_inst (.clock(clock), .reset(reset), .press_go(go), .press_len(plen),
      .amp_cmd(amp_cmd), .mode_button(button), .amp_status(amp_status));
   task automatic give_verdict();
      $display("Comparisons %0d, errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Flash half periods may differ by a counter reload cycle
   task automatic check_near(input int got, input int exp);
      comparisons++;
      if (got < exp - 2 || got > exp + 2)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Idle cycle after each transfer keeps psel from being set twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Cycles between two toggles of the watched light
   task automatic measure(input int s, output int half);
      logic v;
      int n;
      sel = s;
      cycles(4);
      v = watch;
      n = 0;
      while (watch === v && n < 30000) begin cycles(1); n++; end
      v = watch;
      half = 0;
      while (watch === v && half < 30000) begin cycles(1); half++; end
   endtask
   function automatic logic [7:0] light_exp(input logic [2:0] c, input logic [7:0] b, input logic [15:0] w);
      return (c == fpsd_pkg::LIGHT_BYTE_A) ? w[7:0] : (c == fpsd_pkg::LIGHT_BYTE_B) ? w[15:8] : b;
   endfunction
   initial
   begin
      #(90000 * 10);
      n_errors++;
      give_verdict();
   end
   initial
   begin
      void'($urandom(7482));
      cycles(5);
      reset <= 1'b0;
      check32({bit_oe, word_oe}, 32'h00000000);
      apb(1'b0, fpsd_pkg::ADDR_CONFIG, 32'h0);
      check32(rd, 32'h00000000);
      for (int i = 0; i < 6; i++)
      begin
         cfg = (i == 0) ? 32'hFFFFFFFF : $urandom;
         apb(1'b1, fpsd_pkg::ADDR_CONFIG, cfg);
         apb(1'b0, fpsd_pkg::ADDR_CONFIG, 32'h0);
         check32(rd, {16'h0000, cfg[15:0] & fpsd_pkg::CFG_MASK});
         check32({bit_oe, word_oe}, {8'h00, cfg[7:0], {8{cfg[9]}}, {8{cfg[8]}}});
      end
      for (int c = 0; c < 8; c++)
         if (c != 2)
         begin
            bit_in <= 8'($urandom); word_in <= 16'($urandom);
            apb(1'b1, fpsd_pkg::ADDR_CONFIG, {17'h0, c[2:0], 12'h000});
            cycles(3);
            check32(bit_lights, light_exp(c[2:0], bit_in, word_in));
            check32(stamp, bit_in[3:0]);
         end
      apb(1'b1, fpsd_pkg::ADDR_CONFIG, 32'h000003FF);
      cfg = $urandom;
      apb(1'b1, fpsd_pkg::ADDR_DIO, cfg);
      cycles(2);
      check32({bit_out, word_out}, {8'h00, cfg[7:0], cfg[31:16]});
      apb(1'b0, fpsd_pkg::ADDR_DIO, 32'h0);
      check32(rd, {word_in, 8'h00, bit_in});
      apb(1'b0, fpsd_pkg::ADDR_INFO, 32'h0);
      check32(rd, 32'h462B8180);
      apb(1'b0, fpsd_pkg::ADDR_STAMP, 32'h0);
      check32(rd, 32'h5F5E8201);
      apb(1'b1, 12'h020, 32'hFFFFFFFF);
      check32({31'h0, err}, 32'h1);
      apb(1'b0, 12'h020, 32'h0);
      check32(rd, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         {blank, booting} <= i[1:0]; running <= i[0];
         cycles(3);
         check32({disp.message, disp.running}, {i[1:0], i[0]});
      end
      for (int i = 0; i < 4; i++)
      begin
         ind = disp.indicator;
         plen <= 16'h0005; go <= 1'b1;
         cycles(1);
         go <= 1'b0;
         cycles(10);
         check32(disp.indicator, {ind[2:0], ind[3]});
         check32({31'h0, $onehot(disp.indicator)}, 32'h1);
      end
      plen <= 16'h0050; go <= 1'b1;
      cycles(1);
      go <= 1'b0;
      cycles(90);
      check32(disp.auto_cycle, 1'b1);
      ind = disp.indicator;
      h = 0;
      while (disp.indicator === ind && h < 20010) begin cycles(1); h++; end
      check32(disp.indicator, {ind[2:0], ind[3]});
      present <= 5'h1F; load[1] <= fpsd_pkg::LOAD_LIMIT_PCT; load[2] <= 7'h64; cyc_end <= 5'h06;
      cycles(1);
      cyc_end <= 5'h00;
      cycles(3);
      check32(dsp_led[1], 1'b1);
      apb(1'b0, fpsd_pkg::ADDR_DSP_STAT, 32'h0);
      check32(rd, 32'h00008004);
      measure(1, h);
      check_near(h, fpsd_pkg::DSP_FLASH_MS * MS);
      amp_cmd <= 4'b1000;
      cycles(4);
      h = 0;
      repeat (3000) begin cycles(1); h += amp_light; end
      check32(h, 3000);
      amp_cmd <= 4'b1111;
      measure(0, h);
      check_near(h, fpsd_pkg::VRAPID_MS * MS);
      amp_cmd <= 4'b1110;
      measure(0, h);
      check_near(h, fpsd_pkg::RAPID_MS * MS);
      amp_cmd <= 4'b1100;
      measure(0, h);
      check_near(h, fpsd_pkg::SLOW_MS * MS);
      amp_cmd <= 4'b0000;
      measure(0, h);
      check_near(h, fpsd_pkg::VSLOW_MS * MS);
      amp_cmd <= 4'b1011;
      apb(1'b1, fpsd_pkg::ADDR_CONFIG, {17'h0, fpsd_pkg::LIGHT_AMP, 12'h000});
      measure(2, h);
      check_near(h, fpsd_pkg::RAPID_MS * MS);
      measure(3, h);
      check_near(h, fpsd_pkg::VRAPID_MS * MS);
      give_verdict();
   end
endmodule
